/* File: hdl/tmrcc_pkg.sv */
// types shared by the timer channel control block
package tmrcc_pkg;
    typedef enum logic [1:0] {
        TMRCC_ACT_OFF,
        TMRCC_ACT_TOGGLE,
        TMRCC_ACT_LOW,
        TMRCC_ACT_HIGH
    } tmrcc_act_t;
    typedef enum logic [1:0] {
        TMRCC_EDGE_OFF,
        TMRCC_EDGE_RISE,
        TMRCC_EDGE_FALL,
        TMRCC_EDGE_ANY
    } tmrcc_edge_t;
endpackage

/* File: hdl/tmrcc_regs.svh */
// register offsets, field positions and reset values of the timer channel control block
`ifndef TMRCC_REGS_SVH
`define TMRCC_REGS_SVH
`define TMRCC_ADDR_W 4
`define TMRCC_OFS_TOGGLE 4'h0
`define TMRCC_OFS_ACT_UP 4'h1
`define TMRCC_OFS_ACT_LO 4'h2
`define TMRCC_OFS_EDGE_UP 4'h3
`define TMRCC_OFS_EDGE_LO 4'h4
`define TMRCC_OFS_IEN 4'h5
`define TMRCC_OFS_SCR2 4'h6
`define TMRCC_OFS_MASK7 4'h7
`define TMRCC_OFS_LEVEL7 4'h8
`define TMRCC_OFS_CMP7 4'h9
`define TMRCC_OFS_CNT 4'ha
`define TMRCC_OFS_FLAGS 4'hb
`define TMRCC_OFS_OVF 4'hc
`define TMRCC_OFS_ISTAT 4'hd
`define TMRCC_OFS_IMASK 4'he
`define TMRCC_BIT_OVF_IEN 7
`define TMRCC_BIT_CRE 3
`define TMRCC_RST_BYTE 8'h00
`define TMRCC_RST_CNT 16'h0000
`define TMRCC_CNT_MAX 16'hffff
`endif

/* File: hdl/tmrcc_top.sv */
// timer channel control: compare pin actions, capture edges, prescaler, counter, interrupts
//
// Design decisions made here: strobed register access and the register addresses.
`include "tmrcc_regs.svh"
module tmrcc_top
    import tmrcc_pkg::*;
#(
    parameter int NCH = 8
) (
    input wire logic mclk, // bus clock, 100 MHz
    input wire logic rstn, // asynchronous reset, active low
    input wire logic [`TMRCC_ADDR_W-1:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [7:0] rdata, // read data, cycle after rd
    input wire logic [NCH-1:0] direction_select, // 1 = output compare per channel
    input wire logic [NCH-1:0] force_compare, // one-cycle forced compare request
    input wire logic [NCH-1:0] pin_in, // timer pin levels from outside
    output logic [NCH-1:0] pin_out, // compare output lines
    output logic [NCH-1:0] pin_oe, // high while the channel drives its pin
    output logic [NCH-1:0] capture_pulse, // capture event per channel
    output logic [15:0] capture_value, // counter value at the latest capture
    output logic irq // level interrupt request
);

    logic [7:0] toggle_q, act_up_q, act_lo_q, edge_up_q, edge_lo_q, ien_q, scr2_q;
    logic [7:0] mask7_q, level7_q, flags_q, istat_q, imask_q, rdata_q;
    logic ovf_q;
    logic [15:0] cmp7_q, cnt_q, capv_q;
    logic [6:0] pre_cnt_q;
    logic [2:0] pre_sel_q;
    logic [NCH-1:0] pin_q, oe_q, pin_in_q, cap_q;
    logic irq_q;
    logic tick, wrap, hit7, cnt_rst;
    logic [NCH-1:0] cmp_hit, cap_ev;

    // two-bit field of channel ch from an upper/lower register pair
    function automatic logic [1:0] field2(input logic [7:0] up, input logic [7:0] lo,
                                          input int ch);
        logic [15:0] w;
        w = {up, lo};
        return w[2*ch +: 2];
    endfunction

    function automatic logic wsel(input logic [`TMRCC_ADDR_W-1:0] a);
        return wr && (addr == a);
    endfunction

    // control registers: plain storage, no side effects
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            toggle_q <= `TMRCC_RST_BYTE;
            act_up_q <= `TMRCC_RST_BYTE;
            act_lo_q <= `TMRCC_RST_BYTE;
            edge_up_q <= `TMRCC_RST_BYTE;
            edge_lo_q <= `TMRCC_RST_BYTE;
            ien_q <= `TMRCC_RST_BYTE;
            scr2_q <= `TMRCC_RST_BYTE;
            mask7_q <= `TMRCC_RST_BYTE;
            level7_q <= `TMRCC_RST_BYTE;
            imask_q <= `TMRCC_RST_BYTE;
        end else begin
            if (wsel(`TMRCC_OFS_TOGGLE)) toggle_q <= wdata;
            if (wsel(`TMRCC_OFS_ACT_UP)) act_up_q <= wdata;
            if (wsel(`TMRCC_OFS_ACT_LO)) act_lo_q <= wdata;
            if (wsel(`TMRCC_OFS_EDGE_UP)) edge_up_q <= wdata;
            if (wsel(`TMRCC_OFS_EDGE_LO)) edge_lo_q <= wdata;
            if (wsel(`TMRCC_OFS_IEN)) ien_q <= wdata;
            if (wsel(`TMRCC_OFS_SCR2)) scr2_q <= wdata;
            if (wsel(`TMRCC_OFS_MASK7)) mask7_q <= wdata;
            if (wsel(`TMRCC_OFS_LEVEL7)) level7_q <= wdata;
            if (wsel(`TMRCC_OFS_IMASK)) imask_q <= wdata;
        end
    end

    // channel 7 compare value, written high byte then low byte
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmp7_q <= `TMRCC_RST_CNT;
        end else if (wsel(`TMRCC_OFS_CMP7)) begin
            cmp7_q <= {cmp7_q[7:0], wdata};
        end
    end

    // prescaler: the new select is only adopted when all stages are zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pre_cnt_q <= 7'h00;
            pre_sel_q <= 3'h0;
        end else begin
            pre_cnt_q <= 7'(pre_cnt_q + 7'h01);
            if (pre_cnt_q == 7'h00) pre_sel_q <= scr2_q[2:0];
        end
    end

    // tick when the low pre_sel stages have all rolled over; divide by 2^sel
    assign tick = ((pre_cnt_q & 7'((8'h01 << pre_sel_q) - 8'h01)) == 7'h00);
    assign hit7 = tick && (cnt_q == cmp7_q);
    assign cnt_rst = hit7 && scr2_q[`TMRCC_BIT_CRE];
    // with reset enabled and compare-7 at max, reaching max is a compare reset, not an overflow
    assign wrap = tick && (cnt_q == `TMRCC_CNT_MAX) && !cnt_rst;

    // main counter; with compare reset enabled, compare-7 at zero keeps it pinned at zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= `TMRCC_RST_CNT;
        end else if (cnt_rst) begin
            cnt_q <= `TMRCC_RST_CNT;
        end else if (tick) begin
            cnt_q <= 16'(cnt_q + 16'h0001);
        end
    end

    // channel compares: channel 7 uses its own value, channels 0-6 never produce a compare hit here
    // limitation: compare registers of channels 0-6 live outside; their hits come as
    // force_compare-like events only, so here only channel 7 produces a real compare
    assign cmp_hit = {hit7, {(NCH-1){1'b0}}};

    // pin action per channel
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= '0;
            oe_q <= '0;
        end else begin
            for (int ch = 0; ch < NCH; ch++) begin
                tmrcc_act_t act;
                logic own, ovt;
                act = tmrcc_act_t'(field2(act_up_q, act_lo_q, ch));
                oe_q[ch] <= direction_select[ch] &&
                            (act != TMRCC_ACT_OFF || mask7_q[ch]);
                own = cmp_hit[ch] || force_compare[ch];
                ovt = wrap && toggle_q[ch] && direction_select[ch];
                if (hit7 && mask7_q[ch] && direction_select[ch]) begin
                    pin_q[ch] <= level7_q[ch];
                end else if (ovt) begin
                    pin_q[ch] <= ~pin_q[ch];
                end else if (own && direction_select[ch] && !(hit7 && ch != NCH-1)) begin
                    unique case (act)
                        TMRCC_ACT_OFF: pin_q[ch] <= pin_q[ch];
                        TMRCC_ACT_TOGGLE: pin_q[ch] <= ~pin_q[ch];
                        TMRCC_ACT_LOW: pin_q[ch] <= 1'b0;
                        TMRCC_ACT_HIGH: pin_q[ch] <= 1'b1;
                    endcase
                end
            end
        end
    end

    // capture edge detectors on input-capture channels
    always_comb begin
        for (int ch = 0; ch < NCH; ch++) begin
            tmrcc_edge_t e;
            e = tmrcc_edge_t'(field2(edge_up_q, edge_lo_q, ch));
            unique case (e)
                TMRCC_EDGE_OFF: cap_ev[ch] = 1'b0;
                TMRCC_EDGE_RISE: cap_ev[ch] = pin_in[ch] && !pin_in_q[ch];
                TMRCC_EDGE_FALL: cap_ev[ch] = !pin_in[ch] && pin_in_q[ch];
                TMRCC_EDGE_ANY: cap_ev[ch] = pin_in[ch] ^ pin_in_q[ch];
            endcase
            cap_ev[ch] = cap_ev[ch] && !direction_select[ch];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_in_q <= '0;
            cap_q <= '0;
            capv_q <= `TMRCC_RST_CNT;
        end else begin
            pin_in_q <= pin_in;
            cap_q <= cap_ev;
            if (|cap_ev) capv_q <= cnt_q;
        end
    end

    // channel and overflow flags: write one clears, a new event wins over the clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= `TMRCC_RST_BYTE;
            ovf_q <= 1'b0;
        end else begin
            flags_q <= (flags_q & ~(wsel(`TMRCC_OFS_FLAGS) ? wdata : 8'h00)) | cmp_hit | cap_ev;
            if (wrap) ovf_q <= 1'b1;
            else if (wsel(`TMRCC_OFS_OVF) && wdata[7]) ovf_q <= 1'b0;
        end
    end

    // interrupt status: bit0 channel flags, bit1 overflow, bit2 capture; read clears
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            istat_q <= `TMRCC_RST_BYTE;
        end else begin
            istat_q <= (rd && addr == `TMRCC_OFS_ISTAT) ? 8'h00 : istat_q;
            if (|(cmp_hit | cap_ev)) istat_q[0] <= 1'b1;
            if (wrap) istat_q[1] <= 1'b1;
            if (|cap_ev) istat_q[2] <= 1'b1;
        end
    end

    // interrupt line: channel and overflow requests plus masked status
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & ien_q) ||
                     (ovf_q && scr2_q[`TMRCC_BIT_OVF_IEN]) ||
                     |(istat_q & imask_q);
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                `TMRCC_OFS_TOGGLE: rdata_q <= toggle_q;
                `TMRCC_OFS_ACT_UP: rdata_q <= act_up_q;
                `TMRCC_OFS_ACT_LO: rdata_q <= act_lo_q;
                `TMRCC_OFS_EDGE_UP: rdata_q <= edge_up_q;
                `TMRCC_OFS_EDGE_LO: rdata_q <= edge_lo_q;
                `TMRCC_OFS_IEN: rdata_q <= ien_q;
                `TMRCC_OFS_SCR2: rdata_q <= scr2_q;
                `TMRCC_OFS_MASK7: rdata_q <= mask7_q;
                `TMRCC_OFS_LEVEL7: rdata_q <= level7_q;
                `TMRCC_OFS_CMP7: rdata_q <= cmp7_q[7:0];
                `TMRCC_OFS_CNT: rdata_q <= cnt_q[7:0];
                `TMRCC_OFS_FLAGS: rdata_q <= flags_q;
                `TMRCC_OFS_OVF: rdata_q <= {ovf_q, 7'h00};
                `TMRCC_OFS_ISTAT: rdata_q <= istat_q;
                `TMRCC_OFS_IMASK: rdata_q <= imask_q;
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata = rdata_q;
    assign pin_out = pin_q;
    assign pin_oe = oe_q;
    assign capture_pulse = cap_q;
    assign capture_value = capv_q;
    assign irq = irq_q;

    // assertions
    sequence s_wrap_tick;
        wrap && !hit7;
    endsequence

    property p_ovf_toggle;
        @(posedge mclk) disable iff (!rstn)
        s_wrap_tick and (toggle_q[1] && direction_select[1]) |=> pin_q[1] != $past(pin_q[1]);
    endproperty
    a_ovf_toggle: assert property (p_ovf_toggle) else $error("overflow toggle missed");

    property p_ovr7;
        @(posedge mclk) disable iff (!rstn)
        hit7 && mask7_q[1] && direction_select[1] |=> pin_q[1] == $past(level7_q[1]);
    endproperty
    a_ovr7: assert property (p_ovr7) else $error("channel 7 override lost");

    property p_act_low;
        @(posedge mclk) disable iff (!rstn)
        force_compare[2] && direction_select[2] && !hit7 && !wrap && !mask7_q[2] &&
        field2(act_up_q, act_lo_q, 2) == 2'b10 |=> !pin_q[2];
    endproperty
    a_act_low: assert property (p_act_low) else $error("drive low not applied");

    property p_oe;
        @(posedge mclk) disable iff (!rstn)
        direction_select[3] && field2(act_up_q, act_lo_q, 3) != 2'b00 |=> oe_q[3];
    endproperty
    a_oe: assert property (p_oe) else $error("pin not driven");

    property p_cap_rise;
        @(posedge mclk) disable iff (!rstn)
        !direction_select[5] && field2(edge_up_q, edge_lo_q, 5) == 2'b01 &&
        pin_in[5] && !pin_in_q[5] |=> cap_q[5];
    endproperty
    a_cap_rise: assert property (p_cap_rise) else $error("rising capture missed");

    property p_irq_ovf;
        @(posedge mclk) disable iff (!rstn)
        ovf_q && scr2_q[7] |=> irq_q;
    endproperty
    a_irq_ovf: assert property (p_irq_ovf) else $error("overflow irq missing");

    property p_irq_ch;
        @(posedge mclk) disable iff (!rstn)
        flags_q[7] && ien_q[7] |=> irq_q;
    endproperty
    a_irq_ch: assert property (p_irq_ch) else $error("channel irq missing");

    property p_cnt_rst;
        @(posedge mclk) disable iff (!rstn)
        cnt_rst |=> cnt_q == 16'h0000;
    endproperty
    a_cnt_rst: assert property (p_cnt_rst) else $error("counter not reset");

    property p_no_ovf_max;
        @(posedge mclk) disable iff (!rstn)
        scr2_q[3] && cmp7_q == 16'hffff |-> !wrap;
    endproperty
    a_no_ovf_max: assert property (p_no_ovf_max) else $error("overflow with reset at max");

    property p_ovf_set;
        @(posedge mclk) disable iff (!rstn)
        wrap |=> ovf_q ##0 cnt_q == 16'h0000;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

    // toggle code on a forced compare, with no override or overflow in the way
    property p_act_toggle;
        @(posedge mclk) disable iff (!rstn)
        force_compare[1] && direction_select[1] && !hit7 && !wrap && !mask7_q[1] &&
        field2(act_up_q, act_lo_q, 1) == 2'b01 |=> pin_q[1] != $past(pin_q[1]);
    endproperty
    a_act_toggle: assert property (p_act_toggle) else $error("toggle action missed");

    // a disconnected, unmasked channel must leave its pin alone
    property p_oe_off;
        @(posedge mclk) disable iff (!rstn)
        direction_select[0] && field2(act_up_q, act_lo_q, 0) == 2'b00 && !mask7_q[0]
        |=> !oe_q[0];
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven while disconnected");

    property p_cap_fall;
        @(posedge mclk) disable iff (!rstn)
        !direction_select[6] && field2(edge_up_q, edge_lo_q, 6) == 2'b10 &&
        !pin_in[6] && pin_in_q[6] |=> cap_q[6];
    endproperty
    a_cap_fall: assert property (p_cap_fall) else $error("falling capture missed");

    // no source enabled means no request
    property p_irq_quiet;
        @(posedge mclk) disable iff (!rstn)
        !(|(flags_q & ien_q)) && !(ovf_q && scr2_q[`TMRCC_BIT_OVF_IEN]) &&
        !(|(istat_q & imask_q)) |=> !irq_q;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("spurious interrupt");

    property p_cnt_hold;
        @(posedge mclk) disable iff (!rstn)
        scr2_q[`TMRCC_BIT_CRE] && cmp7_q == `TMRCC_RST_CNT && cnt_q == `TMRCC_RST_CNT
        |=> cnt_q == `TMRCC_RST_CNT;
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("counter left zero");

    // the select only moves at the all-zero point of the prescale counter
    property p_pre_hold;
        @(posedge mclk) disable iff (!rstn)
        pre_cnt_q != 7'h00 |=> $stable(pre_sel_q);
    endproperty
    a_pre_hold: assert property (p_pre_hold) else $error("prescale changed early");

    property p_pre_take;
        @(posedge mclk) disable iff (!rstn)
        pre_cnt_q == 7'h00 |=> pre_sel_q == $past(scr2_q[2:0]);
    endproperty
    a_pre_take: assert property (p_pre_take) else $error("prescale not adopted");

    property p_tick_div1;
        @(posedge mclk) disable iff (!rstn)
        pre_sel_q == 3'h0 |-> tick;
    endproperty
    a_tick_div1: assert property (p_tick_div1) else $error("divide by one skipped");
endmodule

/* File: verification/timer_channel_control_tb_top.sv */
// self-checking bench for the timer channel control block
`include "tmrcc_regs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module timer_channel_control_tb_top
    import tmrcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] exp; int kind;} tmrcc_tb_note_t; // kind 0 value, 1 delta, 2 none
    logic mclk, rstn, wr, rd, irq;
    logic [`TMRCC_ADDR_W-1:0] addr;
    logic [7:0] wdata, rdata, direction_select, force_compare, pin_in;
    logic [7:0] pin_out, pin_oe, capture_pulse, seen, got;
    logic [7:0] prev_rd = 8'h00;
    logic [15:0] capture_value;
    logic [31:0] seed;
    logic rd_seen = 1'b0;
    tmrcc_tb_note_t notes[$];
    tmrcc_tb_note_t nt;
    int n_mismatch, checks_done, cycles, cnt;

    tmrcc_top DUT (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .direction_select(direction_select), .force_compare(force_compare),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .capture_pulse(capture_pulse),
        .capture_value(capture_value), .irq(irq));

    // free-running 100 MHz bus clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic complete_run();
        $display("mismatches %0d, comparisons %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // one-cycle write; a gap cycle follows so wr is never assigned twice in a step
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // one-cycle read; the expectation is queued for the watcher
    task automatic bus_rd(input logic [3:0] a, input logic [7:0] e, input int k);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        notes.push_back('{e, k});
        @(posedge mclk);
        rd <= 1'b0;
    endtask

    task automatic pulse_force(input logic [7:0] m);
        @(posedge mclk);
        force_compare <= m;
        @(posedge mclk);
        force_compare <= 8'h00;
        tick(4);
    endtask

    // captures are gathered over a window since the pulse lands a cycle after the edge
    task automatic cap_check(input logic [7:0] lvl, input logic [7:0] e);
        @(posedge mclk);
        pin_in <= lvl;
        seen = 8'h00;
        repeat (4) begin
            @(posedge mclk);
            seen = seen | capture_pulse;
        end
        `CHK(seen, e);
    endtask

    // watcher: read data stand only in the cycle after the strobe, so sample there
    always @(posedge mclk) begin
        if (rd_seen) begin
            if (notes.size() == 0) begin
                `CHK(rdata, 8'hxx);
            end else begin
                nt = notes.pop_front();
                got = (nt.kind == 1) ? rdata - prev_rd : rdata;
                if (nt.kind != 2) `CHK(got, nt.exp);
                prev_rd = rdata;
            end
        end
        rd_seen <= rd;
    end

    // hang guard sized for one full counter wrap plus the short scenarios
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 95000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        {wr, rd, rstn} = 3'h0;
        addr = '0;
        {wdata, direction_select, force_compare, pin_in} = '0;
        seed = 32'h58bd3799;
        tick(10);
        rstn <= 1'b1;
        tick(2);
        // reset values, then random write and read back, then an unmapped place
        for (int a = 0; a < 9; a++) bus_rd(a[3:0], `TMRCC_RST_BYTE, 0);
        for (int a = 0; a < 7; a++) begin
            seed = lfsr_next(seed);
            bus_wr(a[3:0], seed[7:0]);
            bus_rd(a[3:0], seed[7:0], 0);
        end
        bus_wr(4'hf, seed[15:8]);
        bus_rd(4'hf, 8'h00, 0);
        // ch7 flag is up since the first compare hit at zero; enabling it raises the line
        bus_wr(`TMRCC_OFS_IEN, 8'h80);
        tick(2);
        `CHK(irq, 1'b1);
        // ch3..0 compare with every action code, ch7..4 capture with every edge code
        for (int a = 0; a < 9; a++) bus_wr(a[3:0], 8'h00);
        bus_wr(`TMRCC_OFS_ACT_LO,
            {TMRCC_ACT_HIGH, TMRCC_ACT_LOW, TMRCC_ACT_TOGGLE, TMRCC_ACT_OFF});
        bus_wr(`TMRCC_OFS_EDGE_UP,
            {TMRCC_EDGE_ANY, TMRCC_EDGE_FALL, TMRCC_EDGE_RISE, TMRCC_EDGE_OFF});
        @(posedge mclk);
        direction_select <= 8'h0f;
        tick(4);
        `CHK(pin_oe[3:0], 4'b1110);
        pulse_force(8'h0f);
        `CHK(pin_out[3:1], 3'b101);
        pulse_force(8'h02);
        `CHK(pin_out[3:1], 3'b100);
        cap_check(8'hf0, 8'ha0);
        cap_check(8'h00, 8'hc0);
        // each prescale code: 16 timer ticks across a span of 16 divided periods
        for (int p = 0; p < 8; p++) begin
            bus_wr(`TMRCC_OFS_SCR2, p[7:0]);
            tick(300);
            bus_rd(`TMRCC_OFS_CNT, 8'h00, 2);
            tick((16 << p) - 2);
            bus_rd(`TMRCC_OFS_CNT, 8'h10, 1);
        end
        // run to a wrap with toggle on ch1, overflow irq and counter reset on a zero
        // compare value: the counter only meets zero at the wrap, then stays there
        bus_wr(`TMRCC_OFS_CMP7, 8'h00);
        bus_wr(`TMRCC_OFS_CMP7, 8'h00);
        bus_wr(`TMRCC_OFS_SCR2, 8'h88);
        bus_wr(`TMRCC_OFS_TOGGLE, 8'h02);
        bus_wr(`TMRCC_OFS_IMASK, 8'h02);
        bus_rd(`TMRCC_OFS_ISTAT, 8'h00, 2);
        tick(3);
        `CHK(irq, 1'b0);
        cnt = 0;
        while (irq !== 1'b1 && cnt < 70000) begin
            tick(1);
            cnt++;
        end
        tick(2);
        `CHK(irq, 1'b1);
        `CHK(pin_out[1], 1'b1);
        bus_rd(`TMRCC_OFS_OVF, 8'h80, 0);
        bus_wr(`TMRCC_OFS_OVF, 8'h80);
        bus_rd(`TMRCC_OFS_OVF, 8'h00, 0);
        // compare event from the pinned counter plus the overflow event
        bus_rd(`TMRCC_OFS_ISTAT, 8'h03, 0);
        tick(3);
        `CHK(irq, 1'b0);
        for (int i = 0; i < 3; i++) bus_rd(`TMRCC_OFS_CNT, 8'h00, 0);
        // a capture now must latch the pinned zero, not the earlier count
        cap_check(8'hf0, 8'ha0);
        `CHK(capture_value, `TMRCC_RST_CNT);
        tick(4);
        complete_run();
    end
endmodule
